/* File: dv/host_spi_model.sv */
// Host serial flash controller model
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
  // Link toward the device
  output var logic sclk,
  output var logic csN,
  output var logic mosi,
  // Read data from the device
  input wire logic miso,
  input wire logic misoOeN
);
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
  end
  // Sends nb bits MSB first from d[55]; clock idles low between frames
  task automatic xfer(input logic [55:0] d, input int nb, input int slow,
                      output logic [7:0] rd);
    rd = 8'h00;
    csN = 1'b0;
    #24;
    for (int i = 0; i < nb; i++) begin
      mosi = d[55-i];
      #24;
      sclk = 1'b1;
      // No pull on the line: a released output reads as the inverse of the previous bit
      rd = {rd[6:0], misoOeN ? ~rd[0] : miso};
      #24;
      sclk = 1'b0;
    end
    #(24 + slow);
    csN = 1'b1;
    mosi = ~mosi;
    #120;
  endtask
endmodule
`default_nettype wire

/* File: dv/secured_otp_lock_control_sva.sv */
// Checker of the secured OTP lock control ports
`timescale 1ns/1ps
`default_nettype none
module secured_otp_lock_control_sva
  import otp_lock_pkg::*;
(
  // Clocks and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  // Link
  input wire logic csN,
  input wire logic mosi,
  input wire logic miso,
  input wire logic misoOeN,
  // Straps
  input wire logic factoryLockStrap,
  input wire logic customerLockStrap,
  // Core side
  input wire logic otpMode,
  input wire logic arrayWriteBlock,
  input wire logic [SEC_WIDTH-1:0] secStatus,
  input wire logic execPulse,
  input wire logic refusePulse,
  input wire logic [7:0] execOpcode,
  input wire logic [ADDR_WIDTH-1:0] execAddr,
  input wire logic execToOtp,
  input wire logic execSerialArea
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_block_mirror: assert property (arrayWriteBlock == otpMode)
    else $error("array block differs from OTP mode");
  chk_reserved_zero: assert property (secStatus[7:2] == 6'h00)
    else $error("reserved status bits not zero");
  chk_lock_sticky: assert property (secStatus[1] |=> secStatus[1])
    else $error("customer lock cleared");
  chk_factory_hold: assert property (secStatus[0] |=> secStatus[0])
    else $error("factory lock cleared");
  chk_pulse_single: assert property (execPulse |-> !refusePulse ##1 !execPulse)
    else $error("accept pulse malformed");
  chk_otp_no_erase: assert property (execPulse && execToOtp |->
    !(execOpcode inside {8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h01, 8'h31}))
    else $error("erase or status write accepted in OTP mode");
  chk_otp_addr_map: assert property (execPulse && execToOtp |->
    execAddr <= OTP_LAST_ADDR && execSerialArea == (execAddr <= SERIAL_LAST_ADDR))
    else $error("OTP address map wrong");
  chk_locked_no_prog: assert property (execPulse && execToOtp |-> secStatus[1:0] == 2'b00)
    else $error("OTP program accepted while locked");
  chk_read_release: assert property (csN |-> misoOeN)
    else $error("output driven while deselected");
  chk_mode_enter: assert property ($rose(otpMode) |-> $past(csN, 3) && csN)
    else $error("OTP mode entered inside a frame");
  chk_mode_exit: assert property ($fell(otpMode) |-> $past(csN, 3) && csN)
    else $error("OTP mode left inside a frame");
endmodule
bind secured_otp_lock_control secured_otp_lock_control_sva chk (
  .clk(clk), .reset_n(reset_n), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso),
  .misoOeN(misoOeN), .factoryLockStrap(factoryLockStrap),
  .customerLockStrap(customerLockStrap), .otpMode(otpMode),
  .arrayWriteBlock(arrayWriteBlock), .secStatus(secStatus), .execPulse(execPulse),
  .refusePulse(refusePulse), .execOpcode(execOpcode), .execAddr(execAddr),
  .execToOtp(execToOtp), .execSerialArea(execSerialArea));
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the secured OTP lock control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import otp_lock_pkg::*;
  logic clk, reset_n, sclk, csN, mosi, miso, misoOeN, otpMode, arrayWriteBlock;
  logic factoryLockStrap, customerLockStrap, execPulse, refusePulse, execToOtp;
  logic execSerialArea;
  logic [SEC_WIDTH-1:0] secStatus;
  logic [7:0] execOpcode, rd, wd, op;
  logic [ADDR_WIDTH-1:0] execAddr, addr;
  logic [7:0] badOps[7] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h01, 8'h31};
  // Default program opcodes of the design
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_PROGRAM_QUAD = 8'h32;
  int err_count = 0;
  int n_tests = 0;
  int nExec = 0;
  int nRefuse = 0;
  int cycles = 0;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  secured_otp_lock_control DUT (.clk(clk), .reset_n(reset_n), .sclk(sclk), .csN(csN),
    .mosi(mosi), .miso(miso), .misoOeN(misoOeN), .factoryLockStrap(factoryLockStrap),
    .customerLockStrap(customerLockStrap), .otpMode(otpMode),
    .arrayWriteBlock(arrayWriteBlock), .secStatus(secStatus), .execPulse(execPulse),
    .refusePulse(refusePulse), .execOpcode(execOpcode), .execAddr(execAddr),
    .execToOtp(execToOtp), .execSerialArea(execSerialArea));
  host_spi_model HOST (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso),
    .misoOeN(misoOeN));
  // ----------------------------------------
  // Pulse counting and hang guard
  // ----------------------------------------
  always @(negedge clk) begin
    cycles++;
    if (execPulse === 1'b1) nExec++;
    if (refusePulse === 1'b1) nRefuse++;
    if (cycles == 60000) begin
      err_count++;
      results();
    end
  end
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  function automatic logic [7:0] expSec(input logic f, input logic c);
    return {6'h00, c, f};
  endfunction
  // Frame of nb bits, value right-justified; ex or rf below zero skips that count
  task automatic cmd(input logic [55:0] d, input int nb, input int ex, input int rf);
    int e0;
    int r0;
    e0 = nExec;
    r0 = nRefuse;
    HOST.xfer(d << (56 - nb), nb, $urandom_range(0, 100), rd);
    repeat (8) @(negedge clk);
    if (ex >= 0) check(nExec - e0, ex, "accept count");
    if (rf >= 0) check(nRefuse - r0, rf, "refuse count");
  endtask
  task automatic readSec(input logic [7:0] exp);
    HOST.xfer({OP_READ_SEC, 48'h0}, 8 + 8 * $urandom_range(1, 4), 0, rd);
    check(rd, exp, "status read");
    check(misoOeN, 1'b1, "output released");
  endtask
  task automatic resetDut(input logic f, input logic c);
    @(negedge clk);
    reset_n = 1'b0;
    factoryLockStrap = f;
    customerLockStrap = c;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (10) @(negedge clk);
  endtask
  task automatic otpLocked();
    cmd({OP_ENTER_OTP}, 8, -1, -1);
    cmd({OP_PROGRAM, 24'h000020, 8'h11}, 40, 0, 1);
    cmd({OP_EXIT_OTP}, 8, -1, -1);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(36283));
    reset_n = 1'b0;
    factoryLockStrap = 1'b0;
    customerLockStrap = 1'b0;
    resetDut(1'b0, 1'b0);
    readSec(expSec(1'b0, 1'b0));
    cmd({OP_ENTER_OTP}, 8, -1, -1);
    check(otpMode, 1'b1, "otp mode");
    check(arrayWriteBlock, 1'b1, "array block");
    readSec(expSec(1'b0, 1'b0));
    for (int k = 0; k < 6; k++) begin
      addr = (k == 0) ? 24'h00000f : (k == 1) ? 24'h000010 : 24'($urandom_range(0, 511));
      op = k[0] ? OP_PROGRAM_QUAD : OP_PROGRAM;
      cmd({op, addr, 8'($urandom)}, 40, 1, 0);
      check(execSerialArea, addr <= SERIAL_LAST_ADDR, "serial area");
      check(execAddr, addr, "exec address");
      check(execOpcode, op, "exec opcode");
      check(execToOtp, 1'b1, "otp target");
    end
    cmd({OP_PROGRAM, 24'h000200, 8'h5a}, 40, 0, 1);
    foreach (badOps[i]) cmd({badOps[i], 24'h0}, 32, 0, 1);
    cmd({OP_WRITE_SEC, 8'h02}, 16, -1, -1);
    check(secStatus, expSec(1'b0, 1'b0), "write in otp");
    cmd({OP_EXIT_OTP}, 8, -1, -1);
    check(otpMode, 1'b0, "otp left");
    foreach (badOps[i]) cmd({badOps[i], 24'h0}, 32, 1, 0);
    cmd({OP_PROGRAM, 24'h000005, 8'h3c}, 40, 1, 0);
    check(execToOtp, 1'b0, "array target");
    cmd({OP_WRITE_SEC, 4'hf}, 12, -1, -1);
    check(secStatus, expSec(1'b0, 1'b0), "mid-byte write");
    for (int k = 0; k < 3; k++) begin
      wd = 8'($urandom) & 8'hfd;
      cmd({OP_WRITE_SEC, wd}, 16, -1, -1);
      check(secStatus, expSec(1'b0, 1'b0), "clear-bit write");
    end
    cmd({OP_WRITE_SEC, 8'hff}, 16, -1, -1);
    check(secStatus, expSec(1'b0, 1'b1), "lock write");
    cmd({OP_WRITE_SEC, 8'h00}, 16, -1, -1);
    readSec(expSec(1'b0, 1'b1));
    otpLocked();
    resetDut(1'b1, 1'b0);
    readSec(expSec(1'b1, 1'b0));
    otpLocked();
    resetDut(1'b0, 1'b1);
    readSec(expSec(1'b0, 1'b1));
    results();
  end
endmodule
`default_nettype wire

/* File: src/otp_lock_pkg.sv */
// Shared constants for the secured OTP lock control block
package otp_lock_pkg;

  // ------------------------------------------------------------
  // Opcodes handled by this block
  // ------------------------------------------------------------
  localparam logic [7:0] OP_ENTER_OTP = 8'hb1;
  localparam logic [7:0] OP_EXIT_OTP = 8'hc1;
  localparam logic [7:0] OP_READ_SEC = 8'h2b;
  localparam logic [7:0] OP_WRITE_SEC = 8'h2f;

  // ------------------------------------------------------------
  // Security register layout
  // ------------------------------------------------------------
  localparam int SEC_WIDTH = 8;
  localparam int FACTORY_LOCK_POS = 0;
  localparam int CUSTOMER_LOCK_POS = 1;
  localparam logic [SEC_WIDTH-1:0] SEC_RESERVED_READ = 8'h00;

  // ------------------------------------------------------------
  // OTP address map
  // ------------------------------------------------------------
  localparam int ADDR_WIDTH = 24;
  localparam logic [ADDR_WIDTH-1:0] SERIAL_LAST_ADDR = 24'h00000f;
  localparam logic [ADDR_WIDTH-1:0] OTP_LAST_ADDR = 24'h0001ff;

  // ------------------------------------------------------------
  // Frame byte counts and timing counts
  // ------------------------------------------------------------
  localparam logic [2:0] BYTES_OPCODE_ONLY = 3'd1;
  localparam logic [2:0] BYTES_WRITE_SEC = 3'd2;
  localparam logic [2:0] BYTES_PROGRAM_MIN = 3'd5;
  localparam logic [2:0] BYTE_COUNT_MAX = 3'd7;
  localparam logic [2:0] LAST_BIT_OF_BYTE = 3'd7;
  localparam logic [1:0] STRAP_SETTLE = 2'd3;

  // ------------------------------------------------------------
  // Core sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_COLLECT = 3'b010,
    ST_EXEC = 3'b100
  } seq_state_t;

endpackage

/* File: src/otp_spi_link.sv */
// Serial link end: byte assembly and security register read-out
`timescale 1ns/1ps
`default_nettype none
module otp_spi_link
  import otp_lock_pkg::*;
(
  // Link clock and resets
  input wire logic sclk,
  input wire logic reset_n,
  input wire logic csN,
  // Serial data
  input wire logic mosi,
  output logic miso,
  output logic misoOeN,
  // Security register value from the core domain
  input wire logic [SEC_WIDTH-1:0] secStatus,
  // Byte hand-over to the core domain
  output logic [7:0] byteData,
  output logic byteFirst,
  output logic byteTgl,
  output logic partial
);

  logic frameRst_n;
  logic [SEC_WIDTH-1:0] statusS2;
  logic [SEC_WIDTH-1:0] statusS3;
  logic [2:0] bitCnt_r, bitCnt_nxt;
  logic [6:0] shift_r, shift_nxt;
  logic firstDone_r, firstDone_nxt;
  logic readMode_r, readMode_nxt;
  logic [7:0] byteData_r, byteData_nxt;
  logic byteFirst_r, byteFirst_nxt;
  logic byteTgl_r, byteTgl_nxt;
  logic partial_r, partial_nxt;
  logic [7:0] outReg_r, outReg_nxt;
  logic [7:0] shiftIn;
  logic byteDone;

  // Frame logic is cleared by chip select high; the clock is idle then
  assign frameRst_n = reset_n & ~csN;

  // Status changes rarely; it settles during the opcode byte
  otp_sync #(.WIDTH(SEC_WIDTH)) u_status_sync (
    .clk(sclk),
    .reset_n(reset_n),
    .d(secStatus),
    .q2(statusS2),
    .q3(statusS3)
  );

  // ------------------------------------------------------------
  // Receive side
  // ------------------------------------------------------------
  assign shiftIn = {shift_r, mosi};
  assign byteDone = (bitCnt_r == LAST_BIT_OF_BYTE);

  always_comb begin
    bitCnt_nxt = bitCnt_r + 3'd1;
    shift_nxt = shiftIn[6:0];
    firstDone_nxt = firstDone_r;
    readMode_nxt = readMode_r;
    byteData_nxt = byteData_r;
    byteFirst_nxt = byteFirst_r;
    byteTgl_nxt = byteTgl_r;
    if (byteDone) begin
      byteData_nxt = shiftIn;
      byteFirst_nxt = ~firstDone_r;
      byteTgl_nxt = ~byteTgl_r;
      firstDone_nxt = 1'b1;
      if (!firstDone_r && shiftIn == OP_READ_SEC) begin
        readMode_nxt = 1'b1;
      end
    end
    // Survives chip select so the core can see a mid-byte end
    partial_nxt = (bitCnt_nxt != 3'd0);
  end

  always_ff @(posedge sclk or negedge frameRst_n) begin
    if (!frameRst_n) begin
      bitCnt_r <= 3'd0;
      shift_r <= 7'h00;
      firstDone_r <= 1'b0;
      readMode_r <= 1'b0;
    end else begin
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      firstDone_r <= firstDone_nxt;
      readMode_r <= readMode_nxt;
    end
  end

  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      byteData_r <= 8'h00;
      byteFirst_r <= 1'b0;
      byteTgl_r <= 1'b0;
      partial_r <= 1'b0;
    end else begin
      byteData_r <= byteData_nxt;
      byteFirst_r <= byteFirst_nxt;
      byteTgl_r <= byteTgl_nxt;
      partial_r <= partial_nxt;
    end
  end

  // ------------------------------------------------------------
  // Transmit side: status repeats every byte while clocks run
  // ------------------------------------------------------------
  always_comb begin
    if (bitCnt_r == 3'd0) begin
      outReg_nxt = statusS3;
    end else begin
      outReg_nxt = {outReg_r[6:0], 1'b0};
    end
  end

  always_ff @(negedge sclk or negedge frameRst_n) begin
    if (!frameRst_n) begin
      outReg_r <= 8'h00;
    end else begin
      outReg_r <= outReg_nxt;
    end
  end

  assign miso = outReg_r[7];
  assign misoOeN = ~readMode_r;
  assign byteData = byteData_r;
  assign byteFirst = byteFirst_r;
  assign byteTgl = byteTgl_r;
  assign partial = partial_r;

endmodule
`default_nettype wire

/* File: src/otp_sync.sv */
// Three-stage synchroniser for levels entering a clock domain
`timescale 1ns/1ps
`default_nettype none
module otp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset of the receiving domain
  input wire logic clk,
  input wire logic reset_n,
  // Asynchronous input
  input wire logic [WIDTH-1:0] d,
  // Second and third stages; a change counts once they agree
  output logic [WIDTH-1:0] q2,
  output logic [WIDTH-1:0] q3
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign q2 = s2_r;
  assign q3 = s3_r;

endmodule
`default_nettype wire

/* File: src/secured_otp_lock_control.sv */
// Secured OTP mode and security register lock control, top level
`timescale 1ns/1ps
`default_nettype none
module secured_otp_lock_control
  import otp_lock_pkg::*;
#(
  parameter logic [7:0] OP_WRITE_SR1 = 8'h01,
  parameter logic [7:0] OP_WRITE_SR2 = 8'h31,
  parameter logic [7:0] OP_PROGRAM = 8'h02,
  parameter logic [7:0] OP_PROGRAM_QUAD = 8'h32,
  parameter logic [7:0] OP_ERASE_SMALL = 8'h20,
  parameter logic [7:0] OP_ERASE_MID = 8'h52,
  parameter logic [7:0] OP_ERASE_LARGE = 8'hd8,
  parameter logic [7:0] OP_ERASE_CHIP_A = 8'h60,
  parameter logic [7:0] OP_ERASE_CHIP_B = 8'hc7
) (
  // System clock and power-up reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial link from the host
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  output logic miso,
  output logic misoOeN,
  // Non-volatile lock bits as held at power-up
  input wire logic factoryLockStrap,
  input wire logic customerLockStrap,
  // Mode and state toward the flash core
  output logic otpMode,
  output logic arrayWriteBlock,
  output logic [SEC_WIDTH-1:0] secStatus,
  // Write-type command hand-off toward the flash core
  output logic execPulse,
  output logic refusePulse,
  output logic [7:0] execOpcode,
  output logic [ADDR_WIDTH-1:0] execAddr,
  output logic execToOtp,
  output logic execSerialArea
);

  // ------------------------------------------------------------
  // Link instance and crossings
  // ------------------------------------------------------------
  logic [7:0] linkByte;
  logic linkFirst;
  logic linkTgl;
  logic linkPartial;
  logic [4:0] syncIn;
  logic [4:0] syncS2;
  logic [4:0] syncS3;

  otp_spi_link u_link (
    .sclk(sclk),
    .reset_n(reset_n),
    .csN(csN),
    .mosi(mosi),
    .miso(miso),
    .misoOeN(misoOeN),
    .secStatus(secStatus),
    .byteData(linkByte),
    .byteFirst(linkFirst),
    .byteTgl(linkTgl),
    .partial(linkPartial)
  );

  // Chip select crosses inverted so the reset value of the stages is its idle level
  assign syncIn = {customerLockStrap, factoryLockStrap, linkPartial, linkTgl, ~csN};

  otp_sync #(.WIDTH(5)) u_core_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(syncIn),
    .q2(syncS2),
    .q3(syncS3)
  );

  // ------------------------------------------------------------
  // Event detection on synchronised levels
  // ------------------------------------------------------------
  logic tglSeen_r, tglSeen_nxt;
  logic csHigh_r, csHigh_nxt;
  logic partialHeld_r, partialHeld_nxt;
  logic byteEvent;
  logic csRise;
  logic csFall;

  always_comb begin
    tglSeen_nxt = tglSeen_r;
    csHigh_nxt = csHigh_r;
    partialHeld_nxt = partialHeld_r;
    if (syncS2[1] == syncS3[1]) begin
      tglSeen_nxt = syncS3[1];
    end
    if (syncS2[0] == syncS3[0]) begin
      csHigh_nxt = ~syncS3[0];
    end
    if (syncS2[2] == syncS3[2]) begin
      partialHeld_nxt = syncS3[2];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tglSeen_r <= 1'b0;
      csHigh_r <= 1'b1;
      partialHeld_r <= 1'b0;
    end else begin
      tglSeen_r <= tglSeen_nxt;
      csHigh_r <= csHigh_nxt;
      partialHeld_r <= partialHeld_nxt;
    end
  end

  // Byte data stays still for eight link clocks, well past the sync delay
  assign byteEvent = (tglSeen_nxt != tglSeen_r);
  assign csRise = csHigh_nxt & ~csHigh_r;
  assign csFall = ~csHigh_nxt & csHigh_r;

  // ------------------------------------------------------------
  // Lock bits, caught from the straps after reset release
  // ------------------------------------------------------------
  logic [1:0] strapCnt_r, strapCnt_nxt;
  logic factoryLock_r, factoryLock_nxt;
  logic customerLock_r, customerLock_nxt;
  logic otpMode_r, otpMode_nxt;
  logic otpLocked;

  assign otpLocked = factoryLock_r | customerLock_r;

  // ------------------------------------------------------------
  // Frame sequencer
  // ------------------------------------------------------------
  seq_state_t state_r, state_nxt;
  logic [7:0] opcode_r, opcode_nxt;
  logic [2:0] byteCnt_r, byteCnt_nxt;
  logic [ADDR_WIDTH-1:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic execPulse_r, execPulse_nxt;
  logic refusePulse_r, refusePulse_nxt;
  logic [7:0] execOpcode_r, execOpcode_nxt;
  logic [ADDR_WIDTH-1:0] execAddr_r, execAddr_nxt;
  logic execToOtp_r, execToOtp_nxt;
  logic execSerial_r, execSerial_nxt;
  logic onBoundary;
  logic isProgram;
  logic isErase;
  logic isStatusWrite;

  assign onBoundary = ~partialHeld_r & (byteCnt_r != 3'd0);
  assign isProgram = (opcode_r == OP_PROGRAM) || (opcode_r == OP_PROGRAM_QUAD);
  assign isErase = (opcode_r == OP_ERASE_SMALL) || (opcode_r == OP_ERASE_MID) ||
                   (opcode_r == OP_ERASE_LARGE) || (opcode_r == OP_ERASE_CHIP_A) ||
                   (opcode_r == OP_ERASE_CHIP_B);
  assign isStatusWrite = (opcode_r == OP_WRITE_SR1) || (opcode_r == OP_WRITE_SR2);

  always_comb begin
    state_nxt = state_r;
    opcode_nxt = opcode_r;
    byteCnt_nxt = byteCnt_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    strapCnt_nxt = strapCnt_r;
    factoryLock_nxt = factoryLock_r;
    customerLock_nxt = customerLock_r;
    otpMode_nxt = otpMode_r;
    execPulse_nxt = 1'b0;
    refusePulse_nxt = 1'b0;
    execOpcode_nxt = execOpcode_r;
    execAddr_nxt = execAddr_r;
    execToOtp_nxt = execToOtp_r;
    execSerial_nxt = execSerial_r;
    if (strapCnt_r != STRAP_SETTLE) begin
      strapCnt_nxt = strapCnt_r + 2'd1;
      if (strapCnt_nxt == STRAP_SETTLE) begin
        // Straps are steady through reset; the third stage is still one edge behind
        factoryLock_nxt = syncS2[3];
        customerLock_nxt = syncS2[4];
      end
    end
    case (state_r)
      ST_IDLE: begin
        if (csFall) begin
          byteCnt_nxt = 3'd0;
          state_nxt = ST_COLLECT;
        end
      end
      ST_COLLECT: begin
        if (byteEvent) begin
          data_nxt = linkByte;
          if (linkFirst) begin
            opcode_nxt = linkByte;
            byteCnt_nxt = BYTES_OPCODE_ONLY;
          end else begin
            if (byteCnt_r < BYTE_COUNT_MAX) begin
              byteCnt_nxt = byteCnt_r + 3'd1;
            end
            if (byteCnt_r < 3'd4) begin
              addr_nxt = {addr_r[ADDR_WIDTH-9:0], linkByte};
            end
          end
        end
        if (csRise) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_nxt = ST_IDLE;
        execOpcode_nxt = opcode_r;
        execAddr_nxt = addr_r;
        execToOtp_nxt = otpMode_r;
        execSerial_nxt = 1'b0;
        if (opcode_r == OP_ENTER_OTP && byteCnt_r == BYTES_OPCODE_ONLY) begin
          otpMode_nxt = 1'b1;
        end else if (opcode_r == OP_EXIT_OTP && byteCnt_r == BYTES_OPCODE_ONLY) begin
          otpMode_nxt = 1'b0;
        end else if (opcode_r == OP_WRITE_SEC) begin
          // No write-enable latch is consulted here
          if (onBoundary && byteCnt_r == BYTES_WRITE_SEC && !otpMode_r &&
              !customerLock_r) begin
            // Only the lock bit is writable, and only toward one
            customerLock_nxt = data_r[CUSTOMER_LOCK_POS];
          end
        end else if (isStatusWrite) begin
          if (otpMode_r) begin
            refusePulse_nxt = 1'b1;
          end else begin
            execPulse_nxt = 1'b1;
          end
        end else if (isProgram && byteCnt_r >= BYTES_PROGRAM_MIN) begin
          if (!otpMode_r) begin
            execPulse_nxt = 1'b1;
          end else if (otpLocked || addr_r > OTP_LAST_ADDR) begin
            refusePulse_nxt = 1'b1;
          end else begin
            // Program inside the entered OTP window
            execPulse_nxt = 1'b1;
            execSerial_nxt = (addr_r <= SERIAL_LAST_ADDR);
          end
        end else if (isErase) begin
          if (otpMode_r) begin
            refusePulse_nxt = 1'b1;
          end else begin
            execPulse_nxt = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      opcode_r <= 8'h00;
      byteCnt_r <= 3'd0;
      addr_r <= 24'h000000;
      data_r <= 8'h00;
      strapCnt_r <= 2'd0;
      factoryLock_r <= 1'b0;
      customerLock_r <= 1'b0;
      otpMode_r <= 1'b0;
      execPulse_r <= 1'b0;
      refusePulse_r <= 1'b0;
      execOpcode_r <= 8'h00;
      execAddr_r <= 24'h000000;
      execToOtp_r <= 1'b0;
      execSerial_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      opcode_r <= opcode_nxt;
      byteCnt_r <= byteCnt_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      strapCnt_r <= strapCnt_nxt;
      factoryLock_r <= factoryLock_nxt;
      customerLock_r <= customerLock_nxt;
      otpMode_r <= otpMode_nxt;
      execPulse_r <= execPulse_nxt;
      refusePulse_r <= refusePulse_nxt;
      execOpcode_r <= execOpcode_nxt;
      execAddr_r <= execAddr_nxt;
      execToOtp_r <= execToOtp_nxt;
      execSerial_r <= execSerial_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_comb begin
    secStatus = SEC_RESERVED_READ;
    secStatus[FACTORY_LOCK_POS] = factoryLock_r;
    secStatus[CUSTOMER_LOCK_POS] = customerLock_r;
  end

  assign otpMode = otpMode_r;
  assign arrayWriteBlock = otpMode_r;
  assign execPulse = execPulse_r;
  assign refusePulse = refusePulse_r;
  assign execOpcode = execOpcode_r;
  assign execAddr = execAddr_r;
  assign execToOtp = execToOtp_r;
  assign execSerialArea = execSerial_r;

endmodule
`default_nettype wire
